// File: rtl/sipio_top.sv
// top: register port and the two status indicator i/o lines
`timescale 1ns/1ns
module sipio_top
  import sipio_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // instrument state
  input  wire logic        protection_state_indicator_i,
  input  wire logic        output_on_i,
  // line two pin
  input  wire logic        line2_i,
  output logic             line2_o,
  output logic             line2_oe_n_o,
  // line three pin
  input  wire logic        line3_i,
  output logic             line3_o,
  output logic             line3_oe_n_o
);

  logic [SIPIO_CFG_W-1:0]   cfg2_ff;
  logic [SIPIO_CFG_W-1:0]   cfg3_ff;
  logic [31:0]              pwm2_ff;
  logic [31:0]              pwm3_ff;
  logic [SIPIO_PRESC_W-1:0] presc_ff;
  logic                     tick_ff;
  logic                     in2;
  logic                     in3;
  logic [31:0]              nxt_rdata;

  // pack a pwm word from period and low-time fields
  function automatic logic [31:0] pwm_word(input logic [15:0] per, input logic [15:0] lo);
    pwm_word = {lo, per};
  endfunction : pwm_word

  // register writes; reset puts both lines in indicator mode, normal polarity
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg2_ff <= SIPIO_CFG_RST;
      cfg3_ff <= SIPIO_CFG_RST;
      pwm2_ff <= pwm_word(SIPIO_PWM_PER_RST, SIPIO_PWM_LOW_RST);
      pwm3_ff <= pwm_word(SIPIO_PWM_PER_RST, SIPIO_PWM_LOW_RST);
    end else if (wr_i) begin
      if (addr_i == SIPIO_ADDR_LINE2_CFG) begin
        cfg2_ff <= wdata_i[SIPIO_CFG_W-1:0];
      end else if (addr_i == SIPIO_ADDR_LINE3_CFG) begin
        cfg3_ff <= wdata_i[SIPIO_CFG_W-1:0];
      end else if (addr_i == SIPIO_ADDR_LINE2_PWM) begin
        pwm2_ff <= wdata_i;
      end else if (addr_i == SIPIO_ADDR_LINE3_PWM) begin
        pwm3_ff <= wdata_i;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (addr_i == SIPIO_ADDR_LINE2_CFG) begin
      nxt_rdata[SIPIO_CFG_W-1:0] = cfg2_ff;
    end else if (addr_i == SIPIO_ADDR_LINE3_CFG) begin
      nxt_rdata[SIPIO_CFG_W-1:0] = cfg3_ff;
    end else if (addr_i == SIPIO_ADDR_LINE2_PWM) begin
      nxt_rdata = pwm2_ff;
    end else if (addr_i == SIPIO_ADDR_LINE3_PWM) begin
      nxt_rdata = pwm3_ff;
    end else if (addr_i == SIPIO_ADDR_STATUS) begin
      nxt_rdata[SIPIO_ST_IN2_BIT]  = in2;
      nxt_rdata[SIPIO_ST_IN3_BIT]  = in3;
      nxt_rdata[SIPIO_ST_PIN2_BIT] = line2_o;
      nxt_rdata[SIPIO_ST_PIN3_BIT] = line3_o;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? nxt_rdata : 32'h0000_0000;
    end
  end

  // 10 us tick shared by both pwm generators, saves a wide counter per line
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_ff <= '0;
      tick_ff  <= 1'b0;
    end else if (presc_ff == SIPIO_PRESC_W'(SIPIO_TICK_CYC - 1)) begin
      presc_ff <= '0;
      tick_ff  <= 1'b1;
    end else begin
      presc_ff <= presc_ff + 1'b1;
      tick_ff  <= 1'b0;
    end
  end

  // line two: high while no protection is active
  sipio_line u_line2 (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .cfg_i       (cfg2_ff),
    .pwm_i       (pwm2_ff),
    .tick_i      (tick_ff),
    .status_hi_i (~protection_state_indicator_i),
    .pin_i       (line2_i),
    .pin_o       (line2_o),
    .pin_oe_n_o  (line2_oe_n_o),
    .in_level_o  (in2)
  );

  // line three: high while the load output is off
  sipio_line u_line3 (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .cfg_i       (cfg3_ff),
    .pwm_i       (pwm3_ff),
    .tick_i      (tick_ff),
    .status_hi_i (~output_on_i),
    .pin_i       (line3_i),
    .pin_o       (line3_o),
    .pin_oe_n_o  (line3_oe_n_o),
    .in_level_o  (in3)
  );

endmodule : sipio_top

// File: rtl/sipio_pkg.sv
// package: constants and types for the status indicator i/o pins block
package sipio_pkg;

  // register indices (byte address is four times the index)
  localparam logic [3:0] SIPIO_ADDR_LINE2_CFG = 4'h0;
  localparam logic [3:0] SIPIO_ADDR_LINE3_CFG = 4'h1;
  localparam logic [3:0] SIPIO_ADDR_LINE2_PWM = 4'h2;
  localparam logic [3:0] SIPIO_ADDR_LINE3_PWM = 4'h3;
  localparam logic [3:0] SIPIO_ADDR_STATUS    = 4'h4;

  // line configuration fields
  localparam int SIPIO_CFG_FUNC_LSB = 0;  // 2 bits: line function
  localparam int SIPIO_CFG_SRC_LSB  = 2;  // 2 bits: output source
  localparam int SIPIO_CFG_INV_BIT  = 4;  // polarity flip
  localparam int SIPIO_CFG_W        = 5;

  // pwm word: period in 10 us ticks [15:0], low ticks [31:16]
  localparam int SIPIO_PWM_PER_LSB  = 0;
  localparam int SIPIO_PWM_LOW_LSB  = 16;
  localparam int SIPIO_PWM_FIELD_W  = 16;

  // status register bits
  localparam int SIPIO_ST_IN2_BIT   = 0;
  localparam int SIPIO_ST_IN3_BIT   = 1;
  localparam int SIPIO_ST_PIN2_BIT  = 2;
  localparam int SIPIO_ST_PIN3_BIT  = 3;

  // timing: pwm tick of 10 us at a 100 MHz clock
  localparam int SIPIO_CLK_MHZ      = 100;
  localparam int SIPIO_TICK_US      = 10;
  localparam int SIPIO_TICK_CYC     = SIPIO_TICK_US * SIPIO_CLK_MHZ;
  localparam int SIPIO_PRESC_W      = 10;

  // pwm reset: 100 Hz period (1000 ticks), 10 % low (100 ticks)
  localparam logic [15:0] SIPIO_PWM_PER_RST = 16'h03e8;
  localparam logic [15:0] SIPIO_PWM_LOW_RST = 16'h0064;

  typedef enum logic [1:0] {
    SIPIO_FUNC_STATUS,
    SIPIO_FUNC_INPUT,
    SIPIO_FUNC_OUTPUT
  } sipio_func_t;

  typedef enum logic [1:0] {
    SIPIO_SRC_ONE,
    SIPIO_SRC_ZERO,
    SIPIO_SRC_PWM
  } sipio_src_t;

  localparam logic [SIPIO_CFG_W-1:0] SIPIO_CFG_RST = 5'h00;

endpackage : sipio_pkg

// File: rtl/sipio_line.sv
// one configurable i/o line: function select, polarity, pwm and input sync
`timescale 1ns/1ns
module sipio_line
  import sipio_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // configuration
  input  wire logic [4:0]  cfg_i,
  input  wire logic [31:0] pwm_i,
  input  wire logic        tick_i,
  input  wire logic        status_hi_i,
  // pin
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_n_o,
  // sensed input level
  output logic             in_level_o
);

  logic                          sync1_ff;
  logic                          sync2_ff;
  logic [SIPIO_PWM_FIELD_W-1:0]  cnt_ff;
  logic                          pwm_lo_ff;
  logic                          nxt_pin;
  sipio_func_t                   func;
  sipio_src_t                    src;
  logic                          inv;
  logic [SIPIO_PWM_FIELD_W-1:0]  per;
  logic [SIPIO_PWM_FIELD_W-1:0]  low;

  assign func = sipio_func_t'(cfg_i[SIPIO_CFG_FUNC_LSB +: 2]);
  assign src  = sipio_src_t'(cfg_i[SIPIO_CFG_SRC_LSB +: 2]);
  assign inv  = cfg_i[SIPIO_CFG_INV_BIT];
  assign per  = pwm_i[SIPIO_PWM_PER_LSB +: SIPIO_PWM_FIELD_W];
  assign low  = pwm_i[SIPIO_PWM_LOW_LSB +: SIPIO_PWM_FIELD_W];

  // two-flop synchroniser; only the second stage is used
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
    end
  end

  // sensed level, flipped when the line polarity is inverted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_level_o <= 1'b0;
    end else begin
      in_level_o <= sync2_ff ^ inv;
    end
  end

  // pwm period counter; low phase first, then high for the rest
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff    <= '0;
      pwm_lo_ff <= 1'b0;
    end else if (tick_i) begin
      if (cnt_ff + 16'h0001 >= per) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      pwm_lo_ff <= (cnt_ff < low);
    end
  end

  // output level: logic one drives low under normal polarity
  always_comb begin
    nxt_pin = 1'b1;
    case (func)
      SIPIO_FUNC_STATUS: nxt_pin = status_hi_i ^ inv;
      SIPIO_FUNC_OUTPUT: begin
        case (src)
          SIPIO_SRC_ONE:  nxt_pin = inv;
          SIPIO_SRC_ZERO: nxt_pin = ~inv;
          SIPIO_SRC_PWM:  nxt_pin = ~pwm_lo_ff ^ inv;
          default:        nxt_pin = ~inv;
        endcase
      end
      default:           nxt_pin = 1'b1;
    endcase
  end

  // pin driver; enable is low while driving, released in input mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o      <= 1'b1;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_o      <= nxt_pin;
      pin_oe_n_o <= (func == SIPIO_FUNC_INPUT);
    end
  end

endmodule : sipio_line

// File: bench/sipio_ext_model.sv
// far-side instrument model for one i/o line
`timescale 1ns/1ns
module sipio_ext_model (
  // device side of the pin
  input  wire logic dev_i,
  input  wire logic oe_n_i,
  // level the instrument applies while the device listens
  input  wire logic drive_i,
  // resolved wire level
  output logic      wire_o
);
  // the instrument only drives a released line, so no contention is modelled
  assign wire_o = oe_n_i ? drive_i : dev_i;
endmodule : sipio_ext_model

// File: bench/sipio_props.sv
// checker: port-level assertions for the status indicator i/o pins
`timescale 1ns/1ns
module sipio_props (
  // clock, reset and register port
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // instrument state and pins
  input wire logic        protection_state_indicator_i,
  input wire logic        output_on_i,
  input wire logic        line2_o,
  input wire logic        line2_oe_n_o,
  input wire logic        line3_o,
  input wire logic        line3_oe_n_o
);
  logic [4:0] c2_ff, c3_ff, p2_ff, p3_ff;
  logic       up_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow configs; p* is the config the pins follow, one edge behind
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {c2_ff, c3_ff, p2_ff, p3_ff, up_ff} <= '0;
    end else begin
      if (wr_i && addr_i == 4'h0) c2_ff <= wdata_i[4:0];
      if (wr_i && addr_i == 4'h1) c3_ff <= wdata_i[4:0];
      {p2_ff, p3_ff, up_ff} <= {c2_ff, c3_ff, 1'b1};
    end
  end
  ind2_a: assert property (up_ff && p2_ff[1:0] == 2'h0 |->
    line2_o == ($past(protection_state_indicator_i) ~^ p2_ff[4])) else $error("line2 ind");
  ind3_a: assert property (up_ff && p3_ff[1:0] == 2'h0 |->
    line3_o == ($past(output_on_i) ~^ p3_ff[4])) else $error("line3 ind");
  out2_a: assert property (p2_ff[1:0] == 2'h2 && p2_ff[3:2] < 2'h2 |->
    line2_o == (p2_ff[2] ^ p2_ff[4])) else $error("line2 const");
  out3_a: assert property (p3_ff[1:0] == 2'h2 && p3_ff[3:2] < 2'h2 |->
    line3_o == (p3_ff[2] ^ p3_ff[4])) else $error("line3 const");
  dir2_a: assert property (up_ff |-> line2_oe_n_o == (p2_ff[1:0] == 2'h1))
    else $error("line2 dir");
  dir3_a: assert property (up_ff |-> line3_oe_n_o == (p3_ff[1:0] == 2'h1))
    else $error("line3 dir");
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("rdata not idle");
  stat_rd_a: assert property ($past(rd_i) && $past(addr_i) == 4'h4 |->
    rdata_o[3:2] == {$past(line3_o), $past(line2_o)}) else $error("status pins");
  cover property (p2_ff[3:2] == 2'h2 && $fell(line2_o));
  cover property (p2_ff[1:0] == 2'h1 && $past(rd_i));
  cover property (p3_ff[4] && $rose(line3_o));
endmodule : sipio_props

bind sipio_top sipio_props i_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .output_on_i(output_on_i),
  .protection_state_indicator_i(protection_state_indicator_i),
  .line2_o(line2_o), .line2_oe_n_o(line2_oe_n_o),
  .line3_o(line3_o), .line3_oe_n_o(line3_oe_n_o));

// File: bench/tb_status_indicator_io_pins.sv
// testbench: registers, indicators, outputs, inputs and pwm of the two lines
`timescale 1ns/1ns
module tb_status_indicator_io_pins;
  logic        clk_i, rst_n_i, wr_i, rd_i, prot, on_st, drv2, drv3, w2, w3;
  logic        line2_o, line2_oe_n_o, line3_o, line3_oe_n_o;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, rv;
  int          fail_count, n_tests, seed, cyc, k, i;
  sipio_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .protection_state_indicator_i(prot),
    .output_on_i(on_st), .line2_i(w2), .line2_o(line2_o), .line2_oe_n_o(line2_oe_n_o),
    .line3_i(w3), .line3_o(line3_o), .line3_oe_n_o(line3_oe_n_o));
  sipio_ext_model i_ext2 (.dev_i(line2_o), .oe_n_i(line2_oe_n_o), .drive_i(drv2), .wire_o(w2));
  sipio_ext_model i_ext3 (.dev_i(line3_o), .oe_n_i(line3_oe_n_o), .drive_i(drv3), .wire_o(w3));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bus strobes start one edge after entry so back-to-back calls never clash
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, exp);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // low cycles of one line over two whole pwm periods, sampled mid-cycle
  task automatic pwm_low(input logic sel, input int n, input logic [31:0] exp);
    i = 0;
    repeat (n) begin
      @(negedge clk_i);
      if ((sel ? line3_o : line2_o) === 1'b0) i++;
    end
    chk(32'(i), exp);
  endtask : pwm_low
  // constant output: one gives the flip bit itself, zero gives its inverse
  function automatic logic exp_out(input logic zero_sel, input logic inv);
    return zero_sel ^ inv;
  endfunction : exp_out
  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // hang guard: the whole run needs about 50000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rst_n_i, wr_i, rd_i, prot, on_st, drv2, drv3, addr_i, wdata_i} = '0;
    {fail_count, n_tests, cyc} = '0;
    seed = 12;
    wt(3);
    rst_n_i <= 1'b1;
    // reset values first, while the pwm counter is still near zero
    rd(4'h0, 32'h0, '1);
    rd(4'h1, 32'h0, '1);
    rd(4'h2, 32'h0064_03e8, '1);
    wr(4'h7, $random(seed));
    rd(4'h7, 32'h0, '1);
    wr(4'h4, 32'h0);
    rd(4'h4, 32'hf, '1);
    $display("registers done");
    // 5-tick period, 2 ticks low, 1000 cycles a tick
    wr(4'h2, {16'd2, 16'd5});
    wr(4'h0, 32'h0a);
    wt(6000);
    pwm_low(1'b0, 10000, 32'd4000);
    wr(4'h0, 32'h1a);
    wt(6000);
    pwm_low(1'b0, 10000, 32'd6000);
    // line three: 4-tick period, 1 tick low
    wr(4'h3, {16'd1, 16'd4});
    wr(4'h1, 32'h0a);
    wt(6000);
    pwm_low(1'b1, 8000, 32'd2000);
    $display("pwm done");
    for (k = 0; k < 2; k++) begin
      wr(4'h0, {27'h0, k[0], 4'h0});
      wr(4'h1, {27'h0, k[0], 4'h0});
      repeat (4) begin
        @(posedge clk_i);
        {prot, on_st} <= 2'($random(seed));
        wt(3);
        chk(line2_o, 1'(~(prot ^ k[0])));
        chk(line3_o, 1'(~(on_st ^ k[0])));
        chk({line2_oe_n_o, line3_oe_n_o}, 2'h0);
      end
    end
    $display("indicators done");
    for (k = 0; k < 4; k++) begin
      wr(4'h0, {27'h0, k[1], 1'b0, k[0], 2'h2});
      wr(4'h1, {27'h0, ~k[1], 1'b0, ~k[0], 2'h2});
      wt(2);
      chk(line2_o, exp_out(k[0], k[1]));
      chk(line3_o, exp_out(~k[0], ~k[1]));
    end
    // unused source code 3 falls back to a constant zero (high, normal polarity)
    wr(4'h0, 32'h0e);
    wt(2);
    chk(line2_o, 1'b1);
    $display("outputs done");
    for (k = 0; k < 4; k++) begin
      {drv2, drv3} <= 2'($random(seed));
      wr(4'h0, {27'h0, k[0], 4'h1});
      wr(4'h1, {27'h0, k[1], 4'h1});
      wt(5);
      chk({line2_oe_n_o, line3_oe_n_o}, 2'h3);
      rd(4'h4, {30'h0, drv3 ^ k[1], drv2 ^ k[0]}, 32'h3);
    end
    rv = $random(seed);
    wr(4'h3, rv);
    rd(4'h3, rv, '1);
    $display("inputs done");
    test_done();
  end
endmodule : tb_status_indicator_io_pins
